/* File: pkg/rqs_defs.svh */
// offsets, reset values and timing counts of the receive quality register bank
`ifndef RQS_DEFS_SVH
`define RQS_DEFS_SVH

// ==========================================================
// register offsets (byte addresses on the control port)
`define RQS_OFF_PHASE_VAR_HIGH 8'h90
`define RQS_OFF_PHASE_VAR_LOW 8'h94
`define RQS_OFF_BITSYNC_8BIT 8'h98
`define RQS_OFF_RESERVED_A 8'h9C
`define RQS_OFF_RESERVED_B 8'hA0
`define RQS_OFF_SFD_SEARCH_TIME 8'hA4
`define RQS_OFF_DBPSK_CODE 8'hA8

// ==========================================================
// reset values and fixed codes
`define RQS_RST_SFD_SEARCH_TIME 8'hFF
`define RQS_RST_DBPSK_CODE 8'h0A
`define RQS_DQPSK_CODE 8'h14
`define RQS_RST_BYTE 8'h00
`define RQS_RST_WORD 16'h0000

// ==========================================================
// timing counts and antenna index width
`define RQS_UPDATE_SYMBOLS 128
`define RQS_ANT_W 1

`endif

/* File: pkg/rqs_pkg.sv */
// types shared by the receive quality register bank
`default_nettype none
package rqs_pkg;

  // ==========================================================
  // measurements delivered by the demodulator
  typedef struct packed {
    logic [15:0] phase_var;
    logic [15:0] bitsync;
  } rqs_meas_t;

  typedef struct packed {
    logic valid;
    logic [15:0] bitsync;
  } rqs_dwell_t;

  // ==========================================================
  // start frame delimiter search
  typedef enum logic [0:0] {
    RQS_SFD_IDLE,
    RQS_SFD_SEARCH
  } rqs_sfd_state_t;

endpackage
`default_nettype wire

/* File: rtl/placeholder_none.sv */
// intentionally empty compilation unit
`default_nettype none
`default_nettype wire

/* File: rtl/rqs_regs.sv */
// receive quality readouts, sfd search timer and modulation signalling codes
//
// Operation
// RQ1: phase variance bits 8-15 read at 0x90
// RQ2: phase variance bits 0-7 read at 0x94
// RQ3: refresh phase variance every 128 data symbols
// RQ4: bit-sync 8-bit quality read at 0x98
// RQ5: 8-bit quality taken from best antenna dwell
// RQ6: 8-bit quality spans 256 noise levels
// RQ7: slots 39 and 40 reserved, no function
// RQ8: DBPSK code at 0xA8, sent in header
// RQ9: match received signalling field against DBPSK code
// RQ10: abandon sfd search when search time expires
// RQ11: bit-sync pair every 128 symbols, drives drop-lock
// RQ12: DQPSK code 0x14 for send and detect
//
// The plain strobed port was chosen for this implementation.
`include "rqs_defs.svh"
`default_nettype none

module rqs_regs
  import rqs_pkg::*;
#(
  parameter int ANT_W = `RQS_ANT_W,
  parameter int UPDATE_SYMBOLS = `RQS_UPDATE_SYMBOLS
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic symbol_strobe,
  input wire logic rx_data_active,
  input wire rqs_meas_t data_meas,
  input wire rqs_dwell_t dwell,
  input wire logic [ANT_W-1:0] dwell_antenna,
  input wire logic acq_done,
  input wire logic [ANT_W-1:0] best_antenna,
  input wire logic [15:0] drop_lock_threshold,
  input wire logic sfd_search_start,
  input wire logic sfd_detected,
  input wire logic tx_rate_2m,
  input wire logic rx_header_valid,
  input wire logic [7:0] rx_signal_field,
  output logic [15:0] bitsync_quality_pair,
  output logic quality_update,
  output logic drop_lock,
  output logic sfd_searching,
  output logic sfd_timeout,
  output logic [7:0] tx_signal_field,
  output logic rx_is_dbpsk,
  output logic rx_is_dqpsk,
  output logic rx_mod_unknown
);

  // ==========================================================
  // sizing
  localparam int NUM_ANT = 1 << ANT_W;
  localparam int SYM_W = $clog2(UPDATE_SYMBOLS);
  localparam logic [SYM_W-1:0] SYM_LAST = SYM_W'(UPDATE_SYMBOLS - 1);
  localparam logic [7:0] DQPSK_CODE = `RQS_DQPSK_CODE;

  // ==========================================================
  // register storage
  logic [15:0] phase_variance_quality;
  logic [7:0] phase_low_shadow;
  logic [7:0] bitsync_quality_8bit;
  logic [7:0] frame_delimiter_search_time;
  logic [7:0] dbpsk_signal_code;
  logic [SYM_W-1:0] symbol_count;
  logic [15:0] dwell_store [NUM_ANT];
  rqs_sfd_state_t sfd_state;
  rqs_sfd_state_t next_sfd_state;
  logic [7:0] sfd_count;
  logic [7:0] next_sfd_count;
  logic next_sfd_timeout;

  // ==========================================================
  // address decode
  // full 8-bit compare: aliases of the mapped offsets read as unmapped
  wire hit_phase_high = (reg_addr == `RQS_OFF_PHASE_VAR_HIGH);
  wire hit_phase_low = (reg_addr == `RQS_OFF_PHASE_VAR_LOW);
  wire hit_bitsync_8 = (reg_addr == `RQS_OFF_BITSYNC_8BIT);
  wire hit_reserved_a = (reg_addr == `RQS_OFF_RESERVED_A);
  wire hit_reserved_b = (reg_addr == `RQS_OFF_RESERVED_B);
  wire hit_search_time = (reg_addr == `RQS_OFF_SFD_SEARCH_TIME);
  wire hit_dbpsk = (reg_addr == `RQS_OFF_DBPSK_CODE);

  wire wr_search_time = reg_wr & hit_search_time;
  wire wr_dbpsk = reg_wr & hit_dbpsk;
  // reading the high byte freezes the low byte so the pair stays coherent
  wire rd_phase_high = reg_rd & hit_phase_high;

  // ==========================================================
  // read data selection
  wire [7:0] rd_phase_high_val = hit_phase_high ? phase_variance_quality[15:8] : `RQS_RST_BYTE; // RQ1
  wire [7:0] rd_phase_low_val = hit_phase_low ? phase_low_shadow : `RQS_RST_BYTE; // RQ2
  wire [7:0] rd_bitsync_val = hit_bitsync_8 ? bitsync_quality_8bit : `RQS_RST_BYTE; // RQ4
  // reserved slots decode but always return zero and drop writes
  wire [7:0] rd_reserved_val = (hit_reserved_a | hit_reserved_b) ? `RQS_RST_BYTE : `RQS_RST_BYTE; // RQ7
  wire [7:0] rd_search_val = hit_search_time ? frame_delimiter_search_time : `RQS_RST_BYTE;
  wire [7:0] rd_dbpsk_val = hit_dbpsk ? dbpsk_signal_code : `RQS_RST_BYTE;
  wire [7:0] read_value = rd_phase_high_val |
                          rd_phase_low_val |
                          rd_bitsync_val |
                          rd_reserved_val |
                          rd_search_val |
                          rd_dbpsk_val;

  // data stand only in the cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= `RQS_RST_BYTE;
    end else begin
      reg_rdata <= reg_rd ? read_value : `RQS_RST_BYTE;
    end
  end

  // ==========================================================
  // software writable registers
  // reserved slots and read-only places have no write enable at all
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      frame_delimiter_search_time <= `RQS_RST_SFD_SEARCH_TIME;
    end else if (wr_search_time) begin
      frame_delimiter_search_time <= reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dbpsk_signal_code <= `RQS_RST_DBPSK_CODE; // RQ8
    end else if (wr_dbpsk) begin
      dbpsk_signal_code <= reg_wdata; // RQ8
    end
  end

  // ==========================================================
  // symbol counter for the 128 symbol measurement period
  wire symbol_last = (symbol_count == SYM_LAST);
  // the period restarts whenever data reception stops
  wire quality_tick = rx_data_active & symbol_strobe & symbol_last; // RQ3
  wire [SYM_W-1:0] next_symbol_count = symbol_last ? '0 : symbol_count + 1'b1; // RQ3

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      symbol_count <= '0;
    end else if (!rx_data_active) begin
      symbol_count <= '0;
    end else if (symbol_strobe) begin
      symbol_count <= next_symbol_count; // RQ3
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      quality_update <= 1'b0;
    end else begin
      quality_update <= quality_tick;
    end
  end

  // ==========================================================
  // carrier phase variance readout
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase_variance_quality <= `RQS_RST_WORD;
    end else if (quality_tick) begin
      phase_variance_quality <= data_meas.phase_var; // RQ3
    end
  end

  // a refresh between the two byte reads cannot tear the value
  // limitation: the low byte reads zero until the high byte was read once
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase_low_shadow <= `RQS_RST_BYTE;
    end else if (rd_phase_high) begin
      phase_low_shadow <= phase_variance_quality[7:0]; // RQ2
    end
  end

  // ==========================================================
  // per antenna dwell storage during acquisition
  // each antenna keeps its last dwell so a late acq_done still finds it
  genvar g;
  generate
    for (g = 0; g < NUM_ANT; g++) begin : g_dwell
      wire dwell_hit = dwell.valid & (dwell_antenna == ANT_W'(g));
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          dwell_store[g] <= `RQS_RST_WORD;
        end else if (dwell_hit) begin
          dwell_store[g] <= dwell.bitsync;
        end
      end
    end
  endgenerate

  // ==========================================================
  // bit-sync quality pair and 8-bit readout
  // acquisition result wins over a data refresh landing in the same cycle
  wire [15:0] next_bitsync_pair = acq_done ? dwell_store[best_antenna] : data_meas.bitsync; // RQ5
  wire bitsync_load = acq_done | quality_tick; // RQ11
  wire [7:0] next_bitsync_8bit = next_bitsync_pair[15:8]; // RQ4 RQ6

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bitsync_quality_pair <= `RQS_RST_WORD;
    end else if (bitsync_load) begin
      bitsync_quality_pair <= next_bitsync_pair; // RQ11
    end
  end

  // the upper byte keeps the full range: 256 levels of signal to noise
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bitsync_quality_8bit <= `RQS_RST_BYTE;
    end else if (bitsync_load) begin
      bitsync_quality_8bit <= next_bitsync_8bit; // RQ4 RQ6
    end
  end

  // a weak data period asks the demodulator to drop lock, one pulse per period
  // the raw measurement is compared, not the stored pair, to save a cycle
  wire weak_signal = (data_meas.bitsync < drop_lock_threshold);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      drop_lock <= 1'b0;
    end else begin
      drop_lock <= quality_tick & weak_signal; // RQ11
    end
  end

  // ==========================================================
  // start frame delimiter search timer, counted in symbols
  // limitation: a start pulse during a search is ignored, not a restart
  always_comb begin
    next_sfd_state = sfd_state;
    next_sfd_count = sfd_count;
    next_sfd_timeout = 1'b0;
    unique case (sfd_state)
      RQS_SFD_IDLE: begin
        if (sfd_search_start) begin
          next_sfd_state = RQS_SFD_SEARCH;
          next_sfd_count = frame_delimiter_search_time;
        end
      end
      RQS_SFD_SEARCH: begin
        // a delimiter found on the expiring symbol still counts as found
        if (sfd_detected) begin
          next_sfd_state = RQS_SFD_IDLE;
        end else if (symbol_strobe) begin
          if (sfd_count == `RQS_RST_BYTE) begin
            next_sfd_state = RQS_SFD_IDLE; // RQ10
            next_sfd_timeout = 1'b1; // RQ10
          end else begin
            next_sfd_count = sfd_count - 8'h01;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sfd_state <= RQS_SFD_IDLE;
    end else begin
      sfd_state <= next_sfd_state;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sfd_count <= `RQS_RST_BYTE;
    end else begin
      sfd_count <= next_sfd_count;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sfd_timeout <= 1'b0;
    end else begin
      sfd_timeout <= next_sfd_timeout; // RQ10
    end
  end

  // registered from the next state so it rises together with the state
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sfd_searching <= 1'b0;
    end else begin
      sfd_searching <= (next_sfd_state == RQS_SFD_SEARCH);
    end
  end

  // ==========================================================
  // signalling field codes for transmit and receive
  // the dqpsk code is fixed; only the dbpsk code is writable
  wire [7:0] next_tx_signal = tx_rate_2m ? DQPSK_CODE : dbpsk_signal_code; // RQ8 RQ12
  wire match_dbpsk = (rx_signal_field == dbpsk_signal_code); // RQ9
  wire match_dqpsk = (rx_signal_field == DQPSK_CODE); // RQ12

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_signal_field <= `RQS_RST_DBPSK_CODE;
    end else begin
      tx_signal_field <= next_tx_signal;
    end
  end

  // verdict holds until the next received header; dbpsk wins if codes collide
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_is_dbpsk <= 1'b0;
    end else if (rx_header_valid) begin
      rx_is_dbpsk <= match_dbpsk; // RQ9
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_is_dqpsk <= 1'b0;
    end else if (rx_header_valid) begin
      rx_is_dqpsk <= match_dqpsk & ~match_dbpsk; // RQ12
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_mod_unknown <= 1'b0;
    end else if (rx_header_valid) begin
      rx_mod_unknown <= ~match_dbpsk & ~match_dqpsk;
    end
  end

endmodule
`default_nettype wire

/* File: tb/rqs_regs_props.sv */
// concurrent checks on the ports of the receive quality register bank
`default_nettype none
module rqs_regs_props
  import rqs_pkg::*;
#(
  parameter int UPDATE_SYMBOLS = 128
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire rqs_meas_t data_meas,
  input wire logic acq_done,
  input wire logic [15:0] drop_lock_threshold,
  input wire logic sfd_search_start,
  input wire logic sfd_detected,
  input wire logic tx_rate_2m,
  input wire logic rx_header_valid,
  input wire logic [7:0] rx_signal_field,
  input wire logic [15:0] bitsync_quality_pair,
  input wire logic quality_update,
  input wire logic drop_lock,
  input wire logic sfd_searching,
  input wire logic sfd_timeout,
  input wire logic [7:0] tx_signal_field,
  input wire logic rx_is_dbpsk,
  input wire logic rx_is_dqpsk
);
  // ==========================================================
  // checks
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside read slot");
  rsvd_read_a: assert property (reg_rd && (reg_addr == 8'h9C || reg_addr == 8'hA0) |=> reg_rdata == 8'h00)
    else $error("reserved slot read not zero");
  bs8_read_a: assert property (reg_rd && reg_addr == 8'h98 |=> reg_rdata == $past(bitsync_quality_pair[15:8]))
    else $error("8-bit quality not upper pair byte");
  upd_pulse_a: assert property (quality_update |=> !quality_update)
    else $error("update pulse too long");
  drop_cmp_a: assert property (quality_update || drop_lock |->
    quality_update && drop_lock == ($past(data_meas.bitsync) < $past(drop_lock_threshold)))
    else $error("drop lock decision wrong");
  pair_load_a: assert property (quality_update && !$past(acq_done) |->
    bitsync_quality_pair == $past(data_meas.bitsync))
    else $error("pair not loaded on tick");
  tx_code_a: assert property ($past(tx_rate_2m) |-> tx_signal_field == 8'h14)
    else $error("dqpsk code not sent");
  sfd_end_a: assert property (sfd_timeout |-> !sfd_searching && $past(sfd_searching))
    else $error("timeout outside search");
  sfd_start_a: assert property (sfd_search_start && !sfd_searching && !sfd_detected |=> sfd_searching)
    else $error("search did not start");
  dqpsk_det_a: assert property (rx_header_valid && rx_signal_field == 8'h14 |=> rx_is_dqpsk || rx_is_dbpsk)
    else $error("dqpsk header not recognised");

  cover property (quality_update);
  cover property (drop_lock);
  cover property (sfd_timeout);
  cover property (rx_is_dqpsk);
endmodule
`default_nettype wire

/* File: tb/test_rqs_regs.sv */
// self-checking bench for the receive quality register bank
`default_nettype none
module test_rqs_regs;
  import rqs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int UPD = 8;
  logic clock = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, symbol_strobe = 0, rx_data_active = 0;
  logic acq_done = 0, sfd_search_start = 0, sfd_detected = 0, tx_rate_2m = 0, rx_header_valid = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, rx_signal_field = 0, reg_rdata, tx_signal_field, code;
  logic [7:0] n_upd = 0, n_to = 0;
  logic [15:0] drop_lock_threshold = 0, bitsync_quality_pair, b;
  logic [0:0] dwell_antenna = 0, best_antenna = 0;
  rqs_meas_t data_meas = '0;
  rqs_dwell_t dwell = '0;
  logic quality_update, drop_lock, sfd_searching, sfd_timeout, rx_is_dbpsk, rx_is_dqpsk, rx_mod_unknown;
  logic [7:0] ro [6] = '{8'h90, 8'h94, 8'h98, 8'h9C, 8'hA0, 8'h00};
  int err_total = 0, checked = 0, cyc = 0;

  always #20 clock = ~clock;
  rqs_regs #(.UPDATE_SYMBOLS(UPD)) dut_u (.*);

  // ==========================================================
  // tasks
  task automatic end_of_test;
    $display("mismatches %0d of %0d checks", err_total, checked);
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clock);
    reg_wr <= 0;
  endtask
  // read data stand only in the slot after the strobe
  task automatic rc(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= ad;
    reg_rd <= 1;
    @(posedge clock);
    reg_rd <= 0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic sym(input int n);
    repeat (n) begin
      @(posedge clock);
      symbol_strobe <= 1;
      @(posedge clock);
      symbol_strobe <= 0;
    end
  endtask
  task automatic hdr(input logic [7:0] f, input logic [2:0] exp);
    @(posedge clock);
    rx_header_valid <= 1;
    rx_signal_field <= f;
    @(posedge clock);
    rx_header_valid <= 0;
    #1 chk({5'h00, rx_is_dbpsk, rx_is_dqpsk, rx_mod_unknown}, {5'h00, exp});
  endtask

  always @(posedge clock) begin
    cyc <= cyc + 1;
    n_upd <= n_upd + {7'h00, quality_update};
    n_to <= n_to + {7'h00, sfd_timeout};
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(31));
    repeat (20) @(posedge clock);
    reset_n <= 1;
    rc(8'hA4, 8'hFF);
    rc(8'hA8, 8'h0A);
    chk(tx_signal_field, 8'h0A);
    // read-only, reserved and unmapped places ignore writes
    for (int i = 0; i < 6; i++) begin
      wr(ro[i], 8'h5A);
      rc(ro[i], 8'h00);
    end
    // bit 7 set keeps the random code clear of the dqpsk code
    for (int i = 0; i < 6; i++) begin
      code = 8'($urandom) | 8'h80;
      wr(8'hA8, code);
      rc(8'hA8, code);
      tx_rate_2m <= i[0];
      hdr(code, 3'b100);
      hdr(8'h14, 3'b010);
      hdr(code ^ 8'h01, 3'b001);
      chk(tx_signal_field, i[0] ? 8'h14 : code);
    end
    b = 16'($urandom);
    dwell <= {1'b1, ~b};
    @(posedge clock);
    dwell <= {1'b1, b};
    dwell_antenna <= 1;
    @(posedge clock);
    dwell <= '0;
    best_antenna <= 1;
    acq_done <= 1;
    @(posedge clock);
    acq_done <= 0;
    rc(8'h98, b[15:8]);
    rx_data_active <= 1;
    for (int k = 0; k < 2; k++) begin
      data_meas <= rqs_meas_t'($urandom);
      drop_lock_threshold <= k ? 16'h0000 : 16'hFFFF;
      sym(UPD - 1);
      chk(n_upd, 8'(k));
      sym(1);
      rc(8'h90, data_meas.phase_var[15:8]);
      rc(8'h94, data_meas.phase_var[7:0]);
      rc(8'h98, data_meas.bitsync[15:8]);
      chk(bitsync_quality_pair[7:0], data_meas.bitsync[7:0]);
      chk(n_upd, 8'(k + 1));
    end
    rx_data_active <= 0;
    sym(UPD);
    chk(n_upd, 8'h02);
    // second pass ends the search by a found delimiter
    wr(8'hA4, 8'h02);
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      sfd_search_start <= 1;
      @(posedge clock);
      sfd_search_start <= 0;
      sfd_detected <= k[0];
      @(posedge clock);
      sfd_detected <= 0;
      sym(2);
      #1 chk({7'h00, sfd_searching}, {7'h00, !k[0]});
      sym(1);
      repeat (2) @(posedge clock);
      #1 chk(n_to, 8'h01);
    end
    end_of_test();
  end
endmodule

bind rqs_regs rqs_regs_props #(.UPDATE_SYMBOLS(UPDATE_SYMBOLS)) chk_u (.*);
`default_nettype wire
